// File: logic/sram_ctl_cfg.svh
// Purpose: Timing constants and pin layout for the static memory controller.
// Assumes: 50 MHz clock, fastest speed grade of the memory.
// Notes:   Counts derive from nanosecond figures; least times round up.
`ifndef SRAM_CTL_CFG_SVH
`define SRAM_CTL_CFG_SVH

// Clock period in nanoseconds.
`define CLK_PERIOD_NS 20
// Least cycle time between successive accesses.
`define T_CYCLE_NS 10
// Least address set-up to the end of a write.
`define T_ADDR_TO_END_NS 8
// Least write data set-up to the end of a write.
`define T_DATA_TO_END_NS 5
// Least byte select set-up to the end of a write.
`define T_BYTE_TO_END_NS 7
// Longest chip select access time on a read.
`define T_CS_ACCESS_NS 10
// Longest output enable access time on a read.
`define T_OE_ACCESS_NS 5
// Longest bus release after output enable goes inactive.
`define T_OE_RELEASE_NS 5
// Cycle counts, rounded up, never below one.
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define WR_PULSE_CYC `CYC_UP(`T_ADDR_TO_END_NS)
`define RD_WAIT_CYC `CYC_UP(`T_CS_ACCESS_NS)
`define TURN_CYC `CYC_UP(`T_OE_RELEASE_NS)
`define GAP_CYC `CYC_UP(`T_CYCLE_NS)
// Pin widths and timer count width.
`define ADDR_W 16
`define DATA_W 16
`define CNT_W 4
// Idle level of the active-low controls.
`define CTL_IDLE 1'h1

`endif

// File: logic/sram_ctl_pkg.sv
// Purpose: Types for the static memory controller.
// Assumes: Constants live in sram_ctl_cfg.svh.
// Notes:   Holds only the sequencer state type.
package sram_ctl_pkg;
    // Sequencer states of one access.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACCESS,
        ST_WR_PULSE,
        ST_TURN,
        ST_GAP
    } seq_state_t;
endpackage

// File: logic/sram_cycle_timer.sv
// Purpose: Down counter that times each phase of an access.
// Assumes: Load and count are never asked in the same cycle as reset.
// Notes:   done_o is high while the count is zero.
`timescale 1ns/1ns
`include "sram_ctl_cfg.svh"
module sram_cycle_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [`CNT_W-1:0] value_i,
    output logic done_o
);
    // Remaining cycles of the current phase.
    logic [`CNT_W-1:0] count;

    // Load wins over counting so a phase never starts short.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // Zero count means the phase has run its least time.
    assign done_o = (count == '0);
endmodule

// File: logic/sram_ctl.sv
// Purpose: Host controller driving an asynchronous 64K x 16 static memory.
// Assumes: Memory pins are sampled synchronously; fastest speed grade.
// Notes:   One access at a time; req_i is taken only while ready_o is high.
// Function
// [RULE_01] Memory data valid 10 ns after select.
// [RULE_02] Memory data valid 5 ns after enable.
// [RULE_03] Memory holds old data 3 ns.
// [RULE_04] Memory drives no sooner than 3 ns.
// [RULE_05] Memory releases 3 ns after deselect.
// [RULE_06] Memory releases 5 ns after disable.
// [RULE_07] Byte lane data valid within 5 ns.
// [RULE_08] Byte lane released within 5 ns.
// [RULE_09] Address stable 8 ns before write end.
// [RULE_10] Address held until write has ended.
// [RULE_11] Data valid 5 ns before write end.
// [RULE_12] Memory stops driving on write strobe.
// [RULE_13] Memory waits 1 ns after write.
// [RULE_14] Byte selects active 7 ns before end.
// [RULE_15] Write strobe high through every read.
// [RULE_16] Select and enable low through read.
// [RULE_17] Address valid before select falls; the code sets address and select on the same clock edge.
// [RULE_18] Memory captures data on rising strobe.
// [RULE_19] Memory drivers off unless reading.
// [RULE_20] Low select gates low byte lane.
// [RULE_21] Memory ignores controls while deselected.
// [RULE_22] Successive accesses spaced by cycle time.
`timescale 1ns/1ns
`include "sram_ctl_cfg.svh"
module sram_ctl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [`DATA_W-1:0] wdata_i,
    input wire logic [1:0] byte_en_i,
    output logic ready_o,
    output logic rvalid_o,
    output logic [`DATA_W-1:0] rdata_o,
    output logic [`ADDR_W-1:0] mem_addr_o,
    output logic chip_sel_n_o,
    output logic write_n_o,
    output logic out_en_n_o,
    output logic low_byte_sel_n_o,
    output logic high_byte_sel_n_o,
    input wire logic [`DATA_W-1:0] mem_data_i,
    output logic [`DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_n_o
);
    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Current phase of the access.
    sram_ctl_pkg::seq_state_t state;
    // Phase about to be entered.
    sram_ctl_pkg::seq_state_t next_state;
    // High while the phase timer has expired.
    logic phase_done;
    // Pulse that reloads the phase timer.
    logic load;
    // Count loaded for the next phase.
    logic [`CNT_W-1:0] next_count;
    // Converts a cycle count to the timer width on purpose.
    function automatic logic [`CNT_W-1:0] cyc(input int n);
        cyc = n[`CNT_W-1:0];
    endfunction

    // Next phase and its timer load.
    always_comb begin
        next_state = state;
        load = 1'b0;
        next_count = '0;
        case (state)
            sram_ctl_pkg::ST_IDLE: begin
                if (req_i) begin
                    // Strobes fall on the same edge that the address settles.
                    next_state = we_i ? sram_ctl_pkg::ST_WR_PULSE
                                      : sram_ctl_pkg::ST_RD_ACCESS;
                    load = 1'b1;
                    next_count = we_i ? cyc(`WR_PULSE_CYC)
                                      : cyc(`RD_WAIT_CYC);
                end
            end
            sram_ctl_pkg::ST_RD_ACCESS: begin
                if (phase_done) begin
                    next_state = sram_ctl_pkg::ST_TURN;
                    load = 1'b1;
                    next_count = cyc(`TURN_CYC);
                end
            end
            sram_ctl_pkg::ST_WR_PULSE: begin
                if (phase_done) begin
                    next_state = sram_ctl_pkg::ST_GAP;
                    load = 1'b1;
                    next_count = cyc(`GAP_CYC);
                end
            end
            sram_ctl_pkg::ST_TURN: begin
                if (phase_done) begin
                    next_state = sram_ctl_pkg::ST_GAP;
                    load = 1'b1;
                    next_count = cyc(`GAP_CYC);
                end
            end
            sram_ctl_pkg::ST_GAP: begin
                // Idle gap keeps accesses a full cycle time apart.
                if (phase_done) begin
                    next_state = sram_ctl_pkg::ST_IDLE; // [RULE_22]
                end
            end
            default: begin
                next_state = sram_ctl_pkg::ST_IDLE;
            end
        endcase
    end

    // Phase register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= sram_ctl_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase timer shared by every phase.
    sram_cycle_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load),
        .value_i(next_count),
        .done_o(phase_done)
    );

    // Handshake is combinational so a request can follow idle at once.
    assign ready_o = (state == sram_ctl_pkg::ST_IDLE);

    // ------------------------------------------------------------------
    // Address, data and byte lanes
    // ------------------------------------------------------------------
    // Address, write data and lanes latch when a request is taken and
    // stay put until the gap ends, so the write ends with all of them
    // long settled and nothing moves while a strobe is low.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_addr_o <= '0;
            mem_data_o <= '0;
            low_byte_sel_n_o <= `CTL_IDLE;
            high_byte_sel_n_o <= `CTL_IDLE;
        end else if (ready_o && req_i) begin
            mem_addr_o <= addr_i; // [RULE_09] [RULE_10] [RULE_17]
            mem_data_o <= wdata_i; // [RULE_11]
            low_byte_sel_n_o <= ~byte_en_i[0]; // [RULE_14] [RULE_20]
            high_byte_sel_n_o <= ~byte_en_i[1]; // [RULE_14] [RULE_20]
        end else if (state == sram_ctl_pkg::ST_IDLE) begin
            low_byte_sel_n_o <= `CTL_IDLE;
            high_byte_sel_n_o <= `CTL_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------
    // Strobes come from flip-flops so they never glitch on the pins.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_sel_n_o <= `CTL_IDLE;
            write_n_o <= `CTL_IDLE;
            out_en_n_o <= `CTL_IDLE;
            mem_data_oe_n_o <= `CTL_IDLE;
        end else begin
            chip_sel_n_o <= !(next_state == sram_ctl_pkg::ST_RD_ACCESS ||
                              next_state == sram_ctl_pkg::ST_WR_PULSE);
            // Write strobe only in the write phase, never in a read.
            write_n_o <=
                !(next_state == sram_ctl_pkg::ST_WR_PULSE); // [RULE_15]
            out_en_n_o <=
                !(next_state == sram_ctl_pkg::ST_RD_ACCESS); // [RULE_16]
            // Host drives the bus only while the strobe is low; the
            // turnaround phase after a read lets the memory let go first.
            mem_data_oe_n_o <=
                !(next_state == sram_ctl_pkg::ST_WR_PULSE); // [RULE_12]
        end
    end

    // ------------------------------------------------------------------
    // Read capture
    // ------------------------------------------------------------------
    // Data is sampled at the end of the access wait, well after the
    // longest access time, while select and enable are still low.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= 1'b0;
            if (state == sram_ctl_pkg::ST_RD_ACCESS && phase_done) begin
                rdata_o <= mem_data_i; // [RULE_01] [RULE_02] [RULE_07]
                rvalid_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr_start;
        $fell(write_n_o);
    endsequence

    sequence s_wr_end;
        $rose(write_n_o);
    endsequence

    AST_WR_PULSE_LEN: assert property ( // [RULE_09]
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr_start |-> !write_n_o [*2] ##1 write_n_o)
        else $error("Write strobe width wrong.");

    AST_ADDR_STABLE: assert property ( // [RULE_10]
        @(posedge clk_i) disable iff (!rst_n_i)
        !write_n_o |=> $stable(mem_addr_o) || write_n_o)
        else $error("Address moved during a write.");

    AST_DATA_STABLE: assert property ( // [RULE_11]
        @(posedge clk_i) disable iff (!rst_n_i)
        !write_n_o && !$fell(write_n_o) |-> $stable(mem_data_o))
        else $error("Write data moved during a write.");

    AST_BYTE_HELD: assert property ( // [RULE_14]
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr_end |-> $past(!low_byte_sel_n_o || !high_byte_sel_n_o))
        else $error("No byte lane held to the end of a write.");

    AST_NO_WR_IN_RD: assert property ( // [RULE_15]
        @(posedge clk_i) disable iff (!rst_n_i)
        !out_en_n_o |-> write_n_o)
        else $error("Write strobe low during a read.");

    AST_RD_HOLD: assert property ( // [RULE_16]
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(out_en_n_o) |-> !chip_sel_n_o ##1 !out_en_n_o && !chip_sel_n_o)
        else $error("Select or enable dropped during a read.");

    AST_NO_CLASH: assert property ( // [RULE_12]
        @(posedge clk_i) disable iff (!rst_n_i)
        !mem_data_oe_n_o |-> out_en_n_o && !write_n_o)
        else $error("Host drives bus while memory may drive.");

    AST_GAP: assert property ( // [RULE_22]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(chip_sel_n_o) |=> chip_sel_n_o)
        else $error("Accesses not spaced by cycle time.");

    AST_RVALID: assert property ( // [RULE_01]
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(out_en_n_o) |-> ##2 rvalid_o)
        else $error("Read data not returned on time.");
endmodule

// File: sim/sram_mem_model.sv
// Purpose: Behavioural model of the 64K x 16 static memory.
// Assumes: Delays in ns; default figures sit at the slow end of the grade.
// Notes:   Undriven lanes show the inverted word, never a held value.
`timescale 1ns/1ns
module sram_mem_model #(
    parameter int ACC_NS = 10,
    parameter int REL_NS = 3
) (
    input wire logic [15:0] addr_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic lo_n_i,
    input wire logic hi_n_i,
    input wire logic [15:0] host_d_i,
    input wire logic host_oe_n_i,
    output logic [15:0] bus_o
);
    // ------------------------------------------------------------
    // Storage and read path
    // ------------------------------------------------------------
    logic [15:0] mem [0:65535]; // Word storage, unknown until written.
    logic [15:0] q; // Word at the address, late by the hold time.
    wire rd; // Read drive is allowed.
    wire wr; // A write is in progress.
    wire lo_on; // Low lane is driven.
    wire hi_on; // High lane is driven.
    // Old data lingers after an address change.
    assign #3 q = mem[addr_i];
    // Drivers stay off unless selected, enabled and not writing.
    assign rd = !cs_n_i && !oe_n_i && we_n_i;
    // Lanes turn on late and off fast, as a slow part would.
    assign #(ACC_NS, REL_NS) lo_on =
        rd && !lo_n_i;
    assign #(ACC_NS, REL_NS) hi_on =
        rd && !hi_n_i;
    // The host wins where it drives; idle lanes float to a wrong value.
    assign bus_o = !host_oe_n_i ? host_d_i :
        {hi_on ? q[15:8] : ~q[15:8], lo_on ? q[7:0] : ~q[7:0]};
    // ------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------
    assign wr = !cs_n_i && !we_n_i;
    // Whichever strobe rises first ends the write and latches the lanes.
    always @(negedge wr) begin
        if (!lo_n_i) begin
            mem[addr_i][7:0] = host_d_i[7:0];
        end
        if (!hi_n_i) begin
            mem[addr_i][15:8] = host_d_i[15:8];
        end
    end
endmodule

// File: sim/test_async_sram_timing.sv
// Purpose: Self-checking bench for the static memory controller.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   Pin checks run every cycle the chip is selected inside access; the write taken in sc_refused goes unchecked.
`timescale 1ns/1ns
module test_async_sram_timing;
    logic clk_i = 1'h0; // Bus clock, 20 ns period.
    logic rst_n_i = 1'h0; // Reset, held for 20 cycles.
    logic req_i = 1'h0;
    logic we_i = 1'h0;
    logic [15:0] addr_i = 16'h0;
    logic [15:0] wdata_i = 16'h0;
    logic [1:0] byte_en_i = 2'h0;
    logic ready_o, rvalid_o, chip_sel_n_o, write_n_o, out_en_n_o;
    logic low_byte_sel_n_o, high_byte_sel_n_o, mem_data_oe_n_o;
    logic [15:0] rdata_o, mem_addr_o, mem_data_o;
    wire [15:0] bus; // Resolved data pins.
    int err_count = 0;
    int n_compared = 0;
    logic [15:0] q; // Word returned by the last read.
    int n; // Cycles from take to ready.
    sram_ctl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .byte_en_i(byte_en_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
        .rdata_o(rdata_o), .mem_addr_o(mem_addr_o),
        .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o),
        .out_en_n_o(out_en_n_o), .low_byte_sel_n_o(low_byte_sel_n_o),
        .high_byte_sel_n_o(high_byte_sel_n_o), .mem_data_i(bus),
        .mem_data_o(mem_data_o), .mem_data_oe_n_o(mem_data_oe_n_o));
    sram_mem_model #(.ACC_NS(10), .REL_NS(3)) u_mem (.addr_i(mem_addr_o),
        .cs_n_i(chip_sel_n_o), .we_n_i(write_n_o), .oe_n_i(out_en_n_o),
        .lo_n_i(low_byte_sel_n_o), .hi_n_i(high_byte_sel_n_o),
        .host_d_i(mem_data_o), .host_oe_n_i(mem_data_oe_n_o), .bus_o(bus));
    // Free-running clock.
    always #10 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Compares a pin word; case equality so an unknown never matches a known value.
    task automatic chk(input logic [15:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Compares a count kept by the bench.
    task automatic chk_n(input int got, exp, input string what);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("mismatch %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    // One access; pins are judged each cycle the chip is selected.
    task automatic access(input logic w, input logic [15:0] a, d,
        input logic [1:0] be);
        int pulses;
        pulses = 0;
        @(negedge clk_i);
        req_i = 1'h1;
        we_i = w;
        addr_i = a;
        wdata_i = d;
        byte_en_i = be;
        @(negedge clk_i);
        req_i = 1'h0;
        n = 0;
        while (ready_o !== 1'h1 && n < 20) begin
            if (rvalid_o === 1'h1) begin
                q = rdata_o;
                pulses++;
            end
            if (chip_sel_n_o === 1'h0) begin
                chk(mem_addr_o, a, "address");
                if (w) begin
                    chk(mem_data_o, d, "wdata");
                    chk({12'h0, write_n_o, mem_data_oe_n_o, high_byte_sel_n_o,
                        low_byte_sel_n_o}, {14'h0, ~be}, "wpins");
                end else begin
                    chk({12'h0, write_n_o, out_en_n_o, high_byte_sel_n_o,
                        low_byte_sel_n_o}, {14'h2, ~be},
                        "rpins");
                end
            end
            @(negedge clk_i);
            n++;
        end
        if (n >= 20) begin
            chk_n(n, 0, "ready timeout");
            complete_run();
        end
        // A read spends two cycles each in access, turnaround and gap.
        chk_n(n, w ? 4 : 6, "cycle length");
        chk_n(pulses, w ? 0 : 1, "rvalid pulses");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Lane writes merge into one word; each lane lands only on its bits.
    task automatic sc_lanes();
        access(1'h1, 16'h0010, 16'hA5C3, 2'h3);
        access(1'h1, 16'h0010, 16'h1234, 2'h1);
        access(1'h0, 16'h0010, 16'h0000, 2'h3);
        chk(q, 16'hA534, "low lane merge");
        access(1'h1, 16'h0010, 16'h7F00, 2'h2);
        access(1'h0, 16'h0010, 16'h0000, 2'h3);
        chk(q, 16'h7F34, "high lane merge");
    endtask
    // Extreme addresses back to back, then a single-lane read.
    task automatic sc_edges();
        access(1'h1, 16'hFFFF, 16'h0F0F, 2'h3);
        access(1'h1, 16'h0000, 16'hF0F0, 2'h3);
        access(1'h0, 16'hFFFF, 16'h0000, 2'h3);
        chk(q, 16'h0F0F, "top word");
        access(1'h0, 16'h0000, 16'h0000, 2'h1);
        chk({8'h0, q[7:0]}, 16'h00F0, "low lane read");
    endtask
    // A request held while busy must be ignored.
    task automatic sc_refused();
        int i;
        access(1'h1, 16'h0021, 16'h5555, 2'h3);
        @(negedge clk_i);
        req_i = 1'h1;
        addr_i = 16'h0020;
        wdata_i = 16'h1111;
        @(negedge clk_i);
        addr_i = 16'h0021;
        wdata_i = 16'h2222;
        @(negedge clk_i);
        req_i = 1'h0;
        for (i = 0; i < 20 && ready_o !== 1'h1; i++) @(negedge clk_i);
        if (i >= 20) begin
            chk_n(i, 0, "busy wait timeout");
            complete_run();
        end
        access(1'h0, 16'h0021, 16'h0000, 2'h3);
        chk(q, 16'h5555, "busy request ignored");
        access(1'h0, 16'h0020, 16'h0000, 2'h3);
        chk(q, 16'h1111, "taken request");
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'h1;
        chk({10'h0, ready_o, chip_sel_n_o, write_n_o, out_en_n_o,
            high_byte_sel_n_o, low_byte_sel_n_o},
            16'h003F, "idle pins");
        sc_lanes();
        sc_edges();
        sc_refused();
        complete_run();
    end
endmodule
